/* File: design/irq_mask_consts.svh */
// Offsets, field positions and reset values of the interrupt mask logic
`ifndef IRQ_MASK_CONSTS_SVH
`define IRQ_MASK_CONSTS_SVH

`define REG_MASK_OFS      5'h10
`define REG_STATUS_OFS    5'h11
`define REG_CONFIG_OFS    5'h1C

`define BIT_DISC_ROLL     11
`define BIT_FCAR_ROLL     10
`define BIT_RXERR_ROLL    9
`define BIT_LOOP_FAULT    8
`define BIT_RESET_DONE    7
`define BIT_JABBER        6
`define BIT_ANEG_DONE     5
`define BIT_PAR_FAULT     4
`define BIT_PAR_FAIL      3
`define BIT_REMOTE_FAULT  2
`define BIT_PAGE_RX       1

`define BIT_COMPAT_MODE   5

`define MASK_RESET        16'h0080
`define MASK_WRITABLE     16'h0FFE
`define CONFIG_RESET      16'h0000

`endif

/* File: design/irq_mask_pkg.sv */
// Types shared by the interrupt mask logic
package irq_mask_pkg;
    typedef logic [15:0] reg16_t;
    typedef logic [4:0]  reg_addr_t;
    typedef logic [11:1] event_vec_t;
endpackage : irq_mask_pkg

/* File: design/phy_interrupt_mask_logic.sv */
// Interrupt mask, latched status and management interrupt pin of the PHY
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`include "irq_mask_consts.svh"

// Function
// - Mask bit 11 enables interrupt on disconnect counter MSB set; resets 0.
// - Mask bit 10 enables interrupt on false carrier counter MSB set; resets 0.
// - Mask bit 9 enables interrupt on receive error counter MSB set; resets 0.
// - Mask bit 8 enables interrupt on elastic buffer fault in remote loopback.
// - Mask bit 7 enables interrupt on reset and calibration completion; resets 1.
// - Mask bit 6 enables interrupt on 10BASE-T jabber detection; resets 0.
// - Mask bit 5 enables interrupt on auto-negotiation completion; resets 0.
// - Mask bit 4 enables interrupt on parallel detection fault; resets 0.
// - Mask bit 3 enables interrupt on parallel detect of unadvertised technology.
// - Mask bit 2 enables interrupt on remote fault from either source.
// - Mask bit 1 enables interrupt on every page received; resets 0.
// - Compatibility mode disables all mask bits and ignores writes to them.
// - Masked events are still recorded in the status register.
// - Status bits clear when the status register is read.
module phy_interrupt_mask_logic
    import irq_mask_pkg::*;
(
    input  wire logic      CLK_SYS,
    input  wire logic      RESET,
    input  wire reg_addr_t REG_ADDR,
    input  wire reg16_t    REG_WDATA,
    input  wire logic      REG_WR,
    input  wire logic      REG_RD,
    output reg16_t         REG_RDATA,
    input  wire logic      DISC_COUNT_MSB,
    input  wire logic      FCAR_COUNT_MSB,
    input  wire logic      RXERR_COUNT_MSB,
    input  wire logic      LOOP_BUF_FAULT,
    input  wire logic      RESET_CAL_DONE,
    input  wire logic      JABBER_SEEN,
    input  wire logic      ANEG_DONE,
    input  wire logic      PAR_DETECT_FAULT,
    input  wire logic      PAR_DETECT_FAIL,
    input  wire logic      REMOTE_FAULT,
    input  wire logic      PAGE_RECEIVED,
    output logic           COMPAT_MODE,
    output logic           IRQ_N
);
    // ------------------------------------------------------------
    // Event capture
    // ------------------------------------------------------------
    reg16_t     mask;
    reg16_t     config_reg;
    reg16_t     status;
    reg16_t     eff_mask;
    reg16_t     events;
    event_vec_t levels;
    event_vec_t rises;
    logic       wr_mask;
    logic       wr_config;
    logic       rd_status;

    assign levels[`BIT_DISC_ROLL]    = DISC_COUNT_MSB;
    assign levels[`BIT_FCAR_ROLL]    = FCAR_COUNT_MSB;
    assign levels[`BIT_RXERR_ROLL]   = RXERR_COUNT_MSB;
    assign levels[`BIT_LOOP_FAULT]   = LOOP_BUF_FAULT;
    assign levels[`BIT_RESET_DONE]   = RESET_CAL_DONE;
    assign levels[`BIT_JABBER]       = JABBER_SEEN;
    assign levels[`BIT_ANEG_DONE]    = ANEG_DONE;
    assign levels[`BIT_PAR_FAULT]    = PAR_DETECT_FAULT;
    assign levels[`BIT_PAR_FAIL]     = PAR_DETECT_FAIL;
    assign levels[`BIT_REMOTE_FAULT] = REMOTE_FAULT;
    assign levels[`BIT_PAGE_RX]      = PAGE_RECEIVED;

    rising_detect u_edges (
        .clk   (CLK_SYS),
        .reset (RESET),
        .level (levels),
        .rise  (rises)
    );

    assign events    = {4'h0, rises, 1'b0};
    assign wr_mask   = REG_WR && (REG_ADDR == `REG_MASK_OFS);
    assign wr_config = REG_WR && (REG_ADDR == `REG_CONFIG_OFS);
    assign rd_status = REG_RD && (REG_ADDR == `REG_STATUS_OFS);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            mask <= `MASK_RESET;
        end else if (wr_mask && !config_reg[`BIT_COMPAT_MODE]) begin
            mask <= REG_WDATA & `MASK_WRITABLE;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            config_reg <= `CONFIG_RESET;
        end else if (wr_config) begin
            config_reg <= REG_WDATA;
        end
    end

    // Set wins over read clear, so an event in the read cycle is kept for next read
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            status <= '0;
        end else if (rd_status) begin
            status <= events;
        end else begin
            status <= status | events;
        end
    end

    assign eff_mask = config_reg[`BIT_COMPAT_MODE] ? '0 : mask;

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Pin reflects the next status value so it tracks the latched bits exactly
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            IRQ_N <= 1'b1;
        end else if (rd_status) begin
            IRQ_N <= ~|(events & eff_mask);
        end else begin
            IRQ_N <= ~|((status | events) & eff_mask);
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            COMPAT_MODE <= 1'b0;
        end else if (wr_config) begin
            COMPAT_MODE <= REG_WDATA[`BIT_COMPAT_MODE];
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            REG_RDATA <= '0;
        end else if (REG_RD) begin
            unique case (REG_ADDR)
                `REG_MASK_OFS:   REG_RDATA <= eff_mask;
                `REG_STATUS_OFS: REG_RDATA <= status;
                `REG_CONFIG_OFS: REG_RDATA <= config_reg;
                default:         REG_RDATA <= '0;
            endcase
        end else begin
            REG_RDATA <= '0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    mask_reset_a: assert property (@(posedge CLK_SYS) $fell(RESET) |-> mask == 16'h0080)
        else $error("mask reset value wrong");
    compat_lock_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        config_reg[5] |=> $stable(mask))
        else $error("mask changed in compatibility mode");
    masked_record_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (events != 0) |=> ((status & $past(events)) == $past(events)))
        else $error("event not recorded");
    read_clear_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        rd_status && events == 0 |=> status == 0)
        else $error("status not cleared by read");
    read_data_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        rd_status |=> REG_RDATA == $past(status))
        else $error("status read data wrong");
    irq_level_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        !$past(RESET) |-> (IRQ_N == ~|(status & $past(eff_mask))))
        else $error("irq pin does not follow enabled status");
    disc_irq_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        $rose(DISC_COUNT_MSB) && eff_mask[11] |=> !IRQ_N)
        else $error("disconnect rollover missed");
    page_irq_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        $rose(PAGE_RECEIVED) && eff_mask[1] |=> !IRQ_N ##0 status[1])
        else $error("page interrupt missed");
    compat_quiet_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        config_reg[5] && $past(config_reg[5]) |-> IRQ_N)
        else $error("interrupt while compatibility mode");

    // ------------------------------------------------------------
    // Enabled events reach the pin
    // ------------------------------------------------------------
    // Each event is judged on its own input, but the pin is shared, so another pending enabled bit can hide a broken one
    fcar_irq_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        $rose(FCAR_COUNT_MSB) && eff_mask[`BIT_FCAR_ROLL] |=> !IRQ_N)
        else $error("false carrier rollover missed");
    rxerr_irq_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        $rose(RXERR_COUNT_MSB) && eff_mask[`BIT_RXERR_ROLL] |=> !IRQ_N)
        else $error("receive error rollover missed");
    loop_irq_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        $rose(LOOP_BUF_FAULT) && eff_mask[`BIT_LOOP_FAULT] |=> !IRQ_N)
        else $error("loopback fault missed");
    resetdone_irq_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        $rose(RESET_CAL_DONE) && eff_mask[`BIT_RESET_DONE] |=> !IRQ_N)
        else $error("reset complete missed");
    jabber_irq_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        $rose(JABBER_SEEN) && eff_mask[`BIT_JABBER] |=> !IRQ_N)
        else $error("jabber missed");
    aneg_irq_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        $rose(ANEG_DONE) && eff_mask[`BIT_ANEG_DONE] |=> !IRQ_N)
        else $error("auto-negotiation complete missed");
    parfault_irq_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        $rose(PAR_DETECT_FAULT) && eff_mask[`BIT_PAR_FAULT] |=> !IRQ_N)
        else $error("parallel detection fault missed");
    parfail_irq_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        $rose(PAR_DETECT_FAIL) && eff_mask[`BIT_PAR_FAIL] |=> !IRQ_N)
        else $error("parallel fail missed");
    remote_irq_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        $rose(REMOTE_FAULT) && eff_mask[`BIT_REMOTE_FAULT] |=> !IRQ_N)
        else $error("remote fault missed");

    // ------------------------------------------------------------
    // Every event is recorded whatever the mask
    // ------------------------------------------------------------
    disc_rec_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        $rose(DISC_COUNT_MSB) |=> status[`BIT_DISC_ROLL])
        else $error("disconnect rollover not recorded");
    fcar_rec_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        $rose(FCAR_COUNT_MSB) |=> status[`BIT_FCAR_ROLL])
        else $error("false carrier rollover not recorded");
    rxerr_rec_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        $rose(RXERR_COUNT_MSB) |=> status[`BIT_RXERR_ROLL])
        else $error("receive error rollover not recorded");
    loop_rec_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        $rose(LOOP_BUF_FAULT) |=> status[`BIT_LOOP_FAULT])
        else $error("loopback fault not recorded");
    resetdone_rec_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        $rose(RESET_CAL_DONE) |=> status[`BIT_RESET_DONE])
        else $error("reset complete not recorded");
    jabber_rec_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        $rose(JABBER_SEEN) |=> status[`BIT_JABBER])
        else $error("jabber not recorded");
    aneg_rec_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        $rose(ANEG_DONE) |=> status[`BIT_ANEG_DONE])
        else $error("auto-negotiation complete not recorded");
    parfault_rec_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        $rose(PAR_DETECT_FAULT) |=> status[`BIT_PAR_FAULT])
        else $error("parallel detection fault not recorded");
    parfail_rec_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        $rose(PAR_DETECT_FAIL) |=> status[`BIT_PAR_FAIL])
        else $error("parallel fail not recorded");
    remote_rec_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        $rose(REMOTE_FAULT) |=> status[`BIT_REMOTE_FAULT])
        else $error("remote fault not recorded");
    page_rec_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        $rose(PAGE_RECEIVED) |=> status[`BIT_PAGE_RX])
        else $error("page received not recorded");

    // ------------------------------------------------------------
    // Reset state
    // ------------------------------------------------------------
    // Reset is synchronous, so these look one edge after it is sampled
    reset_irq_a: assert property (@(posedge CLK_SYS)
        RESET |=> IRQ_N)
        else $error("interrupt pin active after reset");
    reset_rdata_a: assert property (@(posedge CLK_SYS)
        RESET |=> REG_RDATA == 16'h0000)
        else $error("read data not cleared by reset");
    reset_compat_a: assert property (@(posedge CLK_SYS)
        RESET |=> !COMPAT_MODE)
        else $error("compatibility mode set after reset");
    reset_status_a: assert property (@(posedge CLK_SYS)
        RESET |=> status == 16'h0000)
        else $error("status not cleared by reset");

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    mask_write_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        wr_mask && !config_reg[`BIT_COMPAT_MODE] |=> mask == $past(REG_WDATA & `MASK_WRITABLE))
        else $error("mask write lost");
    config_write_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        wr_config |=> config_reg == $past(REG_WDATA))
        else $error("config write lost");
    mask_read_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        REG_RD && REG_ADDR == `REG_MASK_OFS |=> REG_RDATA == $past(eff_mask))
        else $error("mask read data wrong");
    config_read_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        REG_RD && REG_ADDR == `REG_CONFIG_OFS |=> REG_RDATA == $past(config_reg))
        else $error("config read data wrong");
    rdata_idle_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        !REG_RD |=> REG_RDATA == 16'h0000)
        else $error("read data outside read cycle");
    compat_mirror_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        COMPAT_MODE == config_reg[`BIT_COMPAT_MODE])
        else $error("compatibility output differs from config");
    mask_reserved_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (mask & ~`MASK_WRITABLE) == 16'h0080 || (mask & ~`MASK_WRITABLE) == 16'h0000)
        else $error("reserved mask bits set");
    status_reserved_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (status & ~`MASK_WRITABLE) == 16'h0000)
        else $error("reserved status bits set");
endmodule : phy_interrupt_mask_logic

/* File: design/rising_detect.sv */
// Per-bit rising edge detector for event levels
`timescale 1ns/1ps
`include "irq_mask_consts.svh"
module rising_detect
    import irq_mask_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire event_vec_t level,
    output event_vec_t      rise
);
    event_vec_t last;

    always_ff @(posedge clk) begin
        if (reset) begin
            last <= '0;
        end else begin
            last <= level;
        end
    end

    // Counter MSBs and event levels count once per rise, not while they stay high
    assign rise = level & ~last;
endmodule : rising_detect

/* File: dv/mgmt_station.sv */
// Management station model that drives the register port
`timescale 1ns/1ps
module mgmt_station
    import irq_mask_pkg::*;
(
    input  wire logic   clk,
    output reg_addr_t   addr = 5'h00,
    output reg16_t      wdata = 16'h0000,
    output logic        wr = 1'b0,
    output logic        rd = 1'b0,
    input  wire reg16_t rdata
);
    task automatic wr_reg(input reg_addr_t a, input reg16_t d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    // Read data stand for one cycle only, so take them just after the edge
    task automatic rd_reg(input reg_addr_t a, output reg16_t d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg
endmodule : mgmt_station

/* File: dv/tb_phy_interrupt_mask_logic.sv */
// Self-checking bench of the PHY interrupt mask logic
`timescale 1ns/1ps
`include "irq_mask_consts.svh"
module tb_phy_interrupt_mask_logic
    import irq_mask_pkg::*;
;
    logic       clk_sys;
    logic       reset;
    reg_addr_t  addr;
    reg16_t     wdata;
    reg16_t     rdata;
    reg16_t     d;
    logic       wr;
    logic       rd;
    logic       compat;
    logic       irq_n;
    event_vec_t ev = '0;
    int         fail_count = 0;
    int         checks_done = 0;

    mgmt_station i_mgmt (.clk(clk_sys), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata));
    phy_interrupt_mask_logic i_dut (.CLK_SYS(clk_sys), .RESET(reset), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
        .DISC_COUNT_MSB(ev[11]), .FCAR_COUNT_MSB(ev[10]), .RXERR_COUNT_MSB(ev[9]),
        .LOOP_BUF_FAULT(ev[8]), .RESET_CAL_DONE(ev[7]), .JABBER_SEEN(ev[6]),
        .ANEG_DONE(ev[5]), .PAR_DETECT_FAULT(ev[4]), .PAR_DETECT_FAIL(ev[3]),
        .REMOTE_FAULT(ev[2]), .PAGE_RECEIVED(ev[1]), .COMPAT_MODE(compat), .IRQ_N(irq_n));

    task automatic chk(input reg16_t got, input reg16_t exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Event levels are sampled as edges, so a pulse of one cycle is one event
    task automatic pulse(input int b);
        @(posedge clk_sys);
        ev[b] <= 1'b1;
        @(posedge clk_sys);
        ev[b] <= 1'b0;
        #1;
    endtask : pulse

    task automatic t_access();
        i_mgmt.rd_reg(`REG_MASK_OFS, d);
        chk(d, `MASK_RESET);
        chk({15'h0000, irq_n}, 16'h0001);
        i_mgmt.wr_reg(`REG_MASK_OFS, 16'hFFFF);
        i_mgmt.rd_reg(`REG_MASK_OFS, d);
        chk(d, `MASK_WRITABLE);
        i_mgmt.wr_reg(5'h1F, 16'hFFFF);
        i_mgmt.rd_reg(5'h1F, d);
        chk(d, 16'h0000);
    endtask : t_access

    task automatic t_events();
        for (int b = 1; b <= 11; b++) begin
            pulse(b);
            chk({15'h0000, irq_n}, 16'h0000);
            i_mgmt.rd_reg(`REG_STATUS_OFS, d);
            chk(d, 16'h0001 << b);
            chk({15'h0000, irq_n}, 16'h0001);
            i_mgmt.rd_reg(`REG_STATUS_OFS, d);
            chk(d, 16'h0000);
        end
    endtask : t_events

    task automatic t_masked_compat();
        i_mgmt.wr_reg(`REG_MASK_OFS, 16'h0020);
        pulse(6);
        chk({15'h0000, irq_n}, 16'h0001);
        i_mgmt.rd_reg(`REG_STATUS_OFS, d);
        chk(d, 16'h0040);
        i_mgmt.wr_reg(`REG_CONFIG_OFS, 16'h0020);
        i_mgmt.wr_reg(`REG_MASK_OFS, `MASK_WRITABLE);
        i_mgmt.rd_reg(`REG_MASK_OFS, d);
        chk(d, 16'h0000);
        chk({15'h0000, compat}, 16'h0001);
        pulse(5);
        chk({15'h0000, irq_n}, 16'h0001);
        i_mgmt.rd_reg(`REG_STATUS_OFS, d);
        chk(d, 16'h0020);
        i_mgmt.wr_reg(`REG_CONFIG_OFS, 16'h0000);
        i_mgmt.rd_reg(`REG_MASK_OFS, d);
        chk(d, 16'h0020);
    endtask : t_masked_compat

    task automatic final_report();
        if (fail_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    initial begin
        reset = 1'b1;
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        t_access();
        t_events();
        t_masked_compat();
        final_report();
    end

    // The tests take about a hundred cycles; 50 us leaves a wide margin
    initial begin
        #50000;
        fail_count++;
        final_report();
    end
endmodule : tb_phy_interrupt_mask_logic
